// ===== design/ccr_core.sv
`timescale 1ns/1ns
// Overview of operation
// - Next instruction word is fetched while the current one executes.
// - Sixteen eight-bit working registers with single-cycle access.
// - Two operands read, computed and written back in one cycle.
// - Ports: one or two 8-bit operands, or one 16-bit operand.
// - Implemented registers are numbered 16 through 31.
// - Top six registers pair into three 16-bit data pointers.
// - Any of the three pointers also addresses lookup tables in program memory.
// - Pointers support displacement, post-increment and pre-decrement.
// - ALU works register-register, register-immediate and single register.
// - Status flags are updated after every ALU operation.
// - Status is not saved or restored on interrupts; software does it.
// - Decoder accepts one-word and some two-word instructions.
// - Return address is stored on the stack in data SRAM.
// - Global enable gates interrupts; lower vector has higher priority.
// - 64 I/O addresses mapped at data addresses 0x0000 to 0x003F.
// - Push stores a byte and decrements the stack pointer by one.
// - Calls and interrupt entry push two bytes, pointer minus two.
// - Pop reads a byte and increments the stack pointer by one.
// - Returns pop two bytes and increment the pointer by two.
// - Stack pointer resets to the last internal SRAM address.
// - Stack pointer is two 8-bit I/O registers; high byte optional.
// - Stack pointer low byte at I/O 0x3D, high byte at 0x3E.
`include "ccr_params.svh"
module ccr_core #(
  parameter int          IRQ_N      = 8,
  parameter logic [15:0] SRAM_LAST  = `CCR_SP_RESET,
  parameter bit          HAS_SP_HI  = 1'b1
) (
  input  wire logic                i_clk,
  input  wire logic                i_rst,
  input  wire ccr_pkg::ccr_instr_t i_instr,
  input  wire logic                i_instr_valid,
  input  wire logic [15:0]         i_target,
  input  wire logic [7:0]          i_data_rdata,
  input  wire logic [IRQ_N-1:0]    i_irq,
  output logic [15:0]              o_program_counter,
  output logic                     o_fetch_en,
  output logic [15:0]              o_prog_addr,
  output logic                     o_prog_lut_rd,
  output ccr_pkg::ccr_dbus_t       o_dbus,
  output logic [7:0]               o_status,
  output logic [15:0]              o_stack_top_pointer,
  output logic [IRQ_N-1:0]         o_irq_ack
);
  import ccr_pkg::*;

  typedef enum {ST_RUN, ST_SEQ1, ST_SEQ2, ST_LOAD} ccr_state_t;

  logic [7:0]       regs [16];
  logic [15:0]      sp, next_sp, pc, next_pc, ret_addr, next_ret_addr;
  logic [7:0]       status, next_status;
  ccr_state_t       state, next_state;
  ccr_op_t          seq_op, next_seq_op;
  logic [3:0]       ld_reg, next_ld_reg;
  logic             irq_block, next_irq_block;
  ccr_dbus_t        dbus, next_dbus;
  logic             lut_rd, next_lut_rd;
  logic             fetch_en, next_fetch_en;
  logic [15:0]      prog_addr, next_prog_addr;
  logic [IRQ_N-1:0] ack, next_ack;
  logic             wr_en, wr16;
  logic [3:0]       wr_idx;
  logic [15:0]      wr_val;
  logic [7:0]       a, b, res;
  logic [15:0]      ptr, ptr_new, eaddr;
  logic             alu_op, take_irq;
  int               irq_num;

  // Maps an architectural register number 16..31 onto the 16-entry file.
  function automatic logic [3:0] ridx(input logic [4:0] r);
    return r[3:0];
  endfunction

  // Reads a pointer pair; the low byte sits at the even register.
  function automatic logic [15:0] pair(input logic [3:0] lo);
    return {regs[lo + 4'h1], regs[lo]};
  endfunction

  // Pointer pair low-byte register selected by the decoder field.
  function automatic logic [3:0] ptr_lo(input logic [1:0] s);
    if (s == 2'd0) begin
      return ridx(`CCR_PTR_A_LO);
    end else if (s == 2'd1) begin
      return ridx(`CCR_PTR_B_LO);
    end else begin
      return ridx(`CCR_PTR_C_LO);
    end
  endfunction

  // Register file; one write port that takes either one byte or a pair.
  always_ff @(posedge i_clk) begin
    if (wr_en) begin
      regs[wr_idx] <= wr_val[7:0];
      if (wr16) begin
        regs[wr_idx + 4'h1] <= wr_val[15:8];
      end
    end
  end

  // Interrupt selection: the lowest index is the lowest vector, so it wins.
  always_comb begin
    irq_num = 0;
    for (int k = IRQ_N - 1; k >= 0; k--) begin
      if (i_irq[k]) begin
        irq_num = k;
      end
    end
  end
  assign take_irq = status[`CCR_FLAG_I] && (|i_irq) && !irq_block && state == ST_RUN;

  // Operand fetch; operands come straight from the file so a result written
  // last cycle is already seen, and no stall is needed.
  always_comb begin
    a       = regs[ridx(i_instr.rd)];
    b       = i_instr.use_imm ? i_instr.imm : regs[ridx(i_instr.rr)];
    ptr     = pair(ptr_lo(i_instr.ptr_sel));
    ptr_new = ptr;
    eaddr   = ptr;
    case (i_instr.pmode)
      CCR_PM_DISP: begin
        eaddr = ptr + {10'h000, i_instr.disp};
      end
      CCR_PM_POSTINC: begin
        ptr_new = ptr + 16'h0001;
      end
      default: begin
        ptr_new = ptr - 16'h0001;
        eaddr   = ptr_new;
      end
    endcase
  end

  // Execute stage: ALU, status, stack and sequencing.
  always_comb begin
    next_pc        = pc;
    next_sp        = sp;
    next_status    = status;
    next_state     = state;
    next_seq_op    = seq_op;
    next_ld_reg    = ld_reg;
    next_ret_addr  = ret_addr;
    next_irq_block = 1'b0;
    next_dbus      = '0;
    next_lut_rd    = 1'b0;
    next_ack       = '0;
    wr_en          = 1'b0;
    wr16           = 1'b0;
    wr_idx         = ridx(i_instr.rd);
    wr_val         = '0;
    res            = a;
    alu_op         = 1'b0;
    case (state)
      ST_RUN: begin
        if (take_irq) begin
          // Status is deliberately left alone apart from the global enable.
          next_status[`CCR_FLAG_I] = 1'b0;
          next_ack[irq_num] = 1'b1;
          next_ret_addr = pc;
          next_pc = 16'(irq_num + 1);
          next_seq_op = CCR_OP_CALL;
          next_dbus = '{rd: 1'b0, wr: 1'b1, addr: sp, wdata: pc[7:0]};
          next_sp = sp - 16'h0001;
          next_state = ST_SEQ1;
        end else if (i_instr_valid) begin
          next_pc = pc + (i_instr.two_word ? 16'h0002 : 16'h0001);
          case (i_instr.op)
            CCR_OP_ADD: begin
              {next_status[`CCR_FLAG_C], res} = {1'b0, a} + {1'b0, b};
              next_status[`CCR_FLAG_V] = (a[7] == b[7]) && (res[7] != a[7]);
              next_status[`CCR_FLAG_H] = (a[3] & b[3]) | (b[3] & ~res[3]) | (~res[3] & a[3]);
              alu_op = 1'b1;
            end
            CCR_OP_SUB: begin
              {next_status[`CCR_FLAG_C], res} = {1'b0, a} - {1'b0, b};
              next_status[`CCR_FLAG_V] = (a[7] != b[7]) && (res[7] != a[7]);
              next_status[`CCR_FLAG_H] = (~a[3] & b[3]) | (b[3] & res[3]) | (res[3] & ~a[3]);
              alu_op = 1'b1;
            end
            CCR_OP_AND, CCR_OP_OR, CCR_OP_XOR: begin
              res = (i_instr.op == CCR_OP_AND) ? (a & b) :
                    (i_instr.op == CCR_OP_OR) ? (a | b) : (a ^ b);
              next_status[`CCR_FLAG_V] = 1'b0;
              alu_op = 1'b1;
            end
            CCR_OP_INC, CCR_OP_DEC: begin
              res = (i_instr.op == CCR_OP_INC) ? a + 8'h01 : a - 8'h01;
              next_status[`CCR_FLAG_V] = (i_instr.op == CCR_OP_INC) ? (res == 8'h80) : (res == 8'h7F);
              alu_op = 1'b1;
            end
            CCR_OP_COM: begin
              res = ~a;
              next_status[`CCR_FLAG_C] = 1'b1;
              next_status[`CCR_FLAG_V] = 1'b0;
              alu_op = 1'b1;
            end
            CCR_OP_MOV: begin
              wr_en = 1'b1;
              wr_val = {8'h00, b};
            end
            CCR_OP_ADIW: begin
              wr_en = 1'b1;
              wr16 = 1'b1;
              wr_val = {regs[ridx(i_instr.rd) + 4'h1], a} + {8'h00, b};
              next_status[`CCR_FLAG_Z] = (wr_val == 16'h0000);
              next_status[`CCR_FLAG_N] = wr_val[15];
            end
            CCR_OP_LD, CCR_OP_ST, CCR_OP_LPM: begin
              // Pointer write-back uses the 16-bit result path.
              if (i_instr.pmode != CCR_PM_DISP) begin
                wr_en = 1'b1;
                wr16 = 1'b1;
                wr_idx = ptr_lo(i_instr.ptr_sel);
                wr_val = ptr_new;
              end
              if (i_instr.op == CCR_OP_LPM) begin
                next_lut_rd = 1'b1;
                next_state = ST_LOAD;
              end else if (i_instr.op == CCR_OP_LD) begin
                next_dbus = '{rd: 1'b1, wr: 1'b0, addr: eaddr, wdata: 8'h00};
                next_state = ST_LOAD;
              end else begin
                next_dbus = '{rd: 1'b0, wr: 1'b1, addr: eaddr, wdata: a};
              end
              next_ld_reg = ridx(i_instr.rd);
            end
            CCR_OP_IN, CCR_OP_OUT: begin
              // I/O offsets are the low data addresses; core registers answer here.
              if (i_instr.io_addr == `CCR_IO_SP_LO || i_instr.io_addr == `CCR_IO_SP_HI ||
                  i_instr.io_addr == `CCR_IO_STATUS) begin
                if (i_instr.op == CCR_OP_IN) begin
                  wr_en = 1'b1;
                  wr_val = (i_instr.io_addr == `CCR_IO_SP_LO) ? {8'h00, sp[7:0]} :
                           (i_instr.io_addr == `CCR_IO_SP_HI) ?
                           {8'h00, HAS_SP_HI ? sp[15:8] : 8'h00} : {8'h00, status};
                end else if (i_instr.io_addr == `CCR_IO_SP_LO) begin
                  next_sp[7:0] = a;
                end else if (i_instr.io_addr == `CCR_IO_SP_HI) begin
                  next_sp[15:8] = HAS_SP_HI ? a : 8'h00;
                end else begin
                  next_status = a;
                end
              end else if (i_instr.op == CCR_OP_IN) begin
                next_dbus = '{rd: 1'b1, wr: 1'b0, addr: {10'h000, i_instr.io_addr}, wdata: 8'h00};
                next_ld_reg = ridx(i_instr.rd);
                next_state = ST_LOAD;
              end else begin
                next_dbus = '{rd: 1'b0, wr: 1'b1, addr: {10'h000, i_instr.io_addr}, wdata: a};
              end
            end
            CCR_OP_PUSH: begin
              next_dbus = '{rd: 1'b0, wr: 1'b1, addr: sp, wdata: a};
              next_sp = sp - 16'h0001;
            end
            CCR_OP_POP: begin
              next_sp = sp + 16'h0001;
              next_dbus = '{rd: 1'b1, wr: 1'b0, addr: next_sp, wdata: 8'h00};
              next_ld_reg = ridx(i_instr.rd);
              next_state = ST_LOAD;
            end
            CCR_OP_CALL: begin
              next_ret_addr = next_pc;
              next_pc = i_target;
              next_dbus = '{rd: 1'b0, wr: 1'b1, addr: sp, wdata: next_ret_addr[7:0]};
              next_sp = sp - 16'h0001;
              next_seq_op = CCR_OP_CALL;
              next_state = ST_SEQ1;
            end
            CCR_OP_RET, CCR_OP_INTERRUPT_RETURN_OP: begin
              next_sp = sp + 16'h0001;
              next_dbus = '{rd: 1'b1, wr: 1'b0, addr: next_sp, wdata: 8'h00};
              next_seq_op = i_instr.op;
              next_state = ST_SEQ1;
            end
            CCR_OP_SEI: begin
              next_status[`CCR_FLAG_I] = 1'b1;
              next_irq_block = 1'b1; // The next instruction runs before any interrupt.
            end
            CCR_OP_CLI: begin
              next_status[`CCR_FLAG_I] = 1'b0;
            end
            default: begin
            end
          endcase
          if (alu_op) begin
            wr_en = 1'b1;
            wr_val = {8'h00, res};
            next_status[`CCR_FLAG_Z] = (res == 8'h00);
            next_status[`CCR_FLAG_N] = res[7];
            next_status[`CCR_FLAG_S] = res[7] ^ next_status[`CCR_FLAG_V];
          end
        end
      end
      ST_SEQ1: begin
        if (seq_op == CCR_OP_CALL) begin
          next_dbus = '{rd: 1'b0, wr: 1'b1, addr: sp, wdata: ret_addr[15:8]};
          next_sp = sp - 16'h0001;
          next_state = ST_RUN;
        end else begin
          next_ret_addr[15:8] = i_data_rdata; // Stack holds the high byte on top.
          next_sp = sp + 16'h0001;
          next_dbus = '{rd: 1'b1, wr: 1'b0, addr: next_sp, wdata: 8'h00};
          next_state = ST_SEQ2;
        end
      end
      ST_SEQ2: begin
        next_pc = {ret_addr[15:8], i_data_rdata};
        if (seq_op == CCR_OP_INTERRUPT_RETURN_OP) begin
          next_status[`CCR_FLAG_I] = 1'b1;
        end
        next_irq_block = 1'b1; // One more instruction runs after a return.
        next_state = ST_RUN;
      end
      default: begin
        wr_en = 1'b1;
        wr_idx = ld_reg;
        wr_val = {8'h00, i_data_rdata};
        next_state = ST_RUN;
      end
    endcase
    // Fetch flag and program address are registered so the pins never glitch.
    next_fetch_en  = (next_state == ST_RUN);
    next_prog_addr = next_lut_rd ? eaddr : next_pc;
  end

  // Core state registers.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pc        <= `CCR_PC_RESET;
      sp        <= SRAM_LAST;
      status    <= `CCR_STATUS_RESET;
      state     <= ST_RUN;
      seq_op    <= CCR_OP_NOP;
      ld_reg    <= 4'h0;
      ret_addr  <= 16'h0000;
      irq_block <= 1'b0;
      dbus      <= '0;
      lut_rd    <= 1'b0;
      ack       <= '0;
      fetch_en  <= 1'b1;
      prog_addr <= `CCR_PC_RESET;
    end else begin
      pc        <= next_pc;
      sp        <= next_sp;
      status    <= next_status;
      state     <= next_state;
      seq_op    <= next_seq_op;
      ld_reg    <= next_ld_reg;
      ret_addr  <= next_ret_addr;
      irq_block <= next_irq_block;
      dbus      <= next_dbus;
      lut_rd    <= next_lut_rd;
      ack       <= next_ack;
      fetch_en  <= next_fetch_en;
      prog_addr <= next_prog_addr;
    end
  end

  // Outputs come from registers; a table read shows the pointer's effective address, else the PC.
  assign o_program_counter   = pc;
  assign o_fetch_en          = fetch_en;
  assign o_prog_addr         = prog_addr;
  assign o_prog_lut_rd       = lut_rd;
  assign o_dbus              = dbus;
  assign o_status            = status;
  assign o_stack_top_pointer = sp;
  assign o_irq_ack           = ack;
endmodule

// ===== design/ccr_params.svh
`ifndef CCR_PARAMS_SVH
`define CCR_PARAMS_SVH
// Register numbering of the implemented file.
`define CCR_REG_FIRST      5'h10
`define CCR_REG_LAST       5'h1F
// Pointer pair low-byte register numbers.
`define CCR_PTR_A_LO       5'h1A
`define CCR_PTR_B_LO       5'h1C
`define CCR_PTR_C_LO       5'h1E
// I/O space map.
`define CCR_IO_LAST        16'h003F
`define CCR_IO_SP_LO       6'h3D
`define CCR_IO_SP_HI       6'h3E
`define CCR_IO_STATUS      6'h3F
`define CCR_STACK_FLOOR    16'h0040
// Reset values.
`define CCR_SP_RESET       16'h005F
`define CCR_PC_RESET       16'h0000
`define CCR_STATUS_RESET   8'h00
// Status bit positions.
`define CCR_FLAG_C         0
`define CCR_FLAG_Z         1
`define CCR_FLAG_N         2
`define CCR_FLAG_V         3
`define CCR_FLAG_S         4
`define CCR_FLAG_H         5
`define CCR_FLAG_I         7
`endif

// ===== design/ccr_pkg.sv
package ccr_pkg;
  // Operation selected by the instruction decoder.
  typedef enum logic [4:0] {
    CCR_OP_NOP, CCR_OP_ADD, CCR_OP_SUB, CCR_OP_AND, CCR_OP_OR, CCR_OP_XOR,
    CCR_OP_MOV, CCR_OP_INC, CCR_OP_DEC, CCR_OP_COM, CCR_OP_ADIW,
    CCR_OP_LD, CCR_OP_ST, CCR_OP_LPM, CCR_OP_IN, CCR_OP_OUT,
    CCR_OP_PUSH, CCR_OP_POP, CCR_OP_CALL, CCR_OP_RET, CCR_OP_INTERRUPT_RETURN_OP,
    CCR_OP_SEI, CCR_OP_CLI
  } ccr_op_t;
  // Pointer adjust mode for indirect access.
  typedef enum logic [1:0] {CCR_PM_DISP, CCR_PM_POSTINC, CCR_PM_PREDEC} ccr_pmode_t;
  // Decoded instruction as presented to the core.
  typedef struct packed {
    ccr_op_t    op;
    logic [4:0] rd;
    logic [4:0] rr;
    logic       use_imm;
    logic [7:0] imm;
    logic [1:0] ptr_sel;
    ccr_pmode_t pmode;
    logic [5:0] disp;
    logic [5:0] io_addr;
    logic       two_word;
  } ccr_instr_t;
  // Data-space bus request.
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } ccr_dbus_t;
endpackage

// ===== dv/ccr_assertions.sv
`timescale 1ns/1ns
// Port-level checks of the stack, data bus and interrupt behaviour of the core.
module ccr_assertions
  import ccr_pkg::*;
#(
  parameter int          IRQ_N     = 8,
  parameter logic [15:0] SRAM_LAST = 16'h005F
) (
  input wire logic               i_clk,
  input wire logic               i_rst,
  input wire ccr_instr_t         i_instr,
  input wire logic               i_instr_valid,
  input wire logic [15:0]        i_target,
  input wire logic [7:0]         i_data_rdata,
  input wire logic [IRQ_N-1:0]   i_irq,
  input wire logic [15:0]        o_program_counter,
  input wire logic               o_fetch_en,
  input wire logic [15:0]        o_prog_addr,
  input wire logic               o_prog_lut_rd,
  input wire ccr_dbus_t          o_dbus,
  input wire logic [7:0]         o_status,
  input wire logic [15:0]        o_stack_top_pointer,
  input wire logic [IRQ_N-1:0]   o_irq_ack
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic        take;
  logic [15:0] sp;
  // Only count an instruction as taken when no interrupt can pre-empt it.
  assign take = i_instr_valid && o_fetch_en && !(o_status[7] && |i_irq);
  assign sp = o_stack_top_pointer;

  AST_RESET_STATE: assert property (disable iff (1'b0)
    i_rst |=> sp == SRAM_LAST && o_program_counter == 16'h0000 && o_status == 8'h00)
    else $error("core state not at reset value after reset");
  AST_PUSH_DEC: assert property (
    take && i_instr.op == CCR_OP_PUSH |=> o_dbus.wr && o_dbus.addr == $past(sp)
      && sp == $past(sp) - 16'h0001)
    else $error("push did not store at the pointer and step down by one");
  AST_POP_INC: assert property (
    take && i_instr.op == CCR_OP_POP |=> o_dbus.rd && o_dbus.addr == $past(sp) + 16'h0001
      ##1 sp == $past(sp, 2) + 16'h0001)
    else $error("pop did not read above the pointer and step up by one");
  AST_CALL_PUSH2: assert property (
    take && i_instr.op == CCR_OP_CALL |=> o_dbus.wr && o_dbus.addr == $past(sp)
      && o_program_counter == $past(i_target)
      ##1 o_dbus.wr && o_dbus.addr == $past(sp, 2) - 16'h0001 && sp == $past(sp, 2) - 16'h0002)
    else $error("call did not push two bytes and step down by two");
  AST_RET_POP2: assert property (
    take && i_instr.op == CCR_OP_RET |=> o_dbus.rd && o_dbus.addr == $past(sp) + 16'h0001
      ##1 o_dbus.rd ##1 sp == $past(sp, 3) + 16'h0002)
    else $error("return did not pop two bytes and step up by two");
  AST_IRQ_PRIO: assert property (
    |o_irq_ack |-> $past(o_status[7])
      && o_irq_ack == ($past(i_irq) & (~$past(i_irq) + 1'b1)))
    else $error("interrupt acknowledged without enable or out of priority");
  AST_IRQ_CLR_I: assert property (
    $rose(|o_irq_ack) |=> !o_status[7])
    else $error("global enable still set after interrupt entry");
  AST_IO_MAP: assert property (
    take && i_instr.op == CCR_OP_OUT && i_instr.io_addr < 6'h3D
      |=> o_dbus.wr && o_dbus.addr == {10'h000, $past(i_instr.io_addr)})
    else $error("io write not placed at its data-space address");
  AST_SP_LOW_IO: assert property (
    take && i_instr.op == CCR_OP_OUT && i_instr.io_addr == 6'h3D
      |=> !o_dbus.wr && sp[15:8] == $past(sp[15:8]))
    else $error("stack pointer low byte write leaked outside");
  AST_ALU_ONE_CYCLE: assert property (
    take && i_instr.op inside {CCR_OP_ADD, CCR_OP_INC}
      |=> o_fetch_en && !o_dbus.wr && !o_dbus.rd && sp == $past(sp))
    else $error("alu operation did not finish in one cycle");
  AST_POP_REFETCH: assert property (
    take && i_instr.op == CCR_OP_POP |=> ##[1:2] o_fetch_en)
    else $error("fetch not resumed after a pop");

  COV_PUSH: cover property (take && i_instr.op == CCR_OP_PUSH);
  COV_CALL: cover property (take && i_instr.op == CCR_OP_CALL);
  COV_IRQ: cover property (|o_irq_ack);
endmodule

// ===== dv/ccr_data_mem.sv
`timescale 1ns/1ns
// Data SRAM and outer io space behind the core's data bus.
module ccr_data_mem
  import ccr_pkg::*;
(
  input  wire logic      i_clk,
  input  wire ccr_dbus_t i_dbus,
  output logic [7:0]     o_rdata
);
  logic [7:0] mem [0:255];
  logic [7:0] last = 8'h00;
  // Writes land at the edge that ends the strobe; reads answer while the read
  // strobe stands, because the core takes load data at that same edge.
  always @(posedge i_clk) begin
    if (i_dbus.wr) begin
      mem[i_dbus.addr[7:0]] <= i_dbus.wdata;
    end
    if (i_dbus.rd) begin
      last <= mem[i_dbus.addr[7:0]];
    end
  end
  // An idle bus shows the inverse of the last read, so stale data never looks valid.
  assign o_rdata = i_dbus.rd ? mem[i_dbus.addr[7:0]] : ~last;
endmodule

// ===== dv/test_cpu_core_regfile_stack.sv
`timescale 1ns/1ns
module test_cpu_core_regfile_stack;
  import ccr_pkg::*;
  logic        i_clk;
  logic        i_rst;
  logic        i_instr_valid;
  ccr_instr_t  i_instr;
  logic [15:0] i_target;
  logic [15:0] pc;
  logic [15:0] sp;
  logic [15:0] prog_addr;
  logic [7:0]  rdata;
  logic [7:0]  status;
  logic [3:0]  irq;
  logic [3:0]  ack;
  logic        fetch_en;
  logic        lut_rd;
  ccr_dbus_t   dbus;
  int          n_fail;
  int          compares;
  int          k;

  ccr_core #(.IRQ_N(4)) u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_instr(i_instr),
    .i_instr_valid(i_instr_valid), .i_target(i_target), .i_data_rdata(rdata),
    .i_irq(irq), .o_program_counter(pc), .o_fetch_en(fetch_en), .o_prog_addr(prog_addr),
    .o_prog_lut_rd(lut_rd), .o_dbus(dbus), .o_status(status), .o_stack_top_pointer(sp),
    .o_irq_ack(ack));
  ccr_data_mem u_mem (.i_clk(i_clk), .i_dbus(dbus), .o_rdata(rdata));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  function automatic ccr_instr_t mk(ccr_op_t op, logic [4:0] r, logic [4:0] s, logic [5:0] io);
    mk = '0;
    mk.op = op;
    mk.rd = r;
    mk.rr = s;
    mk.io_addr = io;
  endfunction
  // Present an instruction; it stays valid until the next go or fin.
  task automatic go(input ccr_instr_t x);
    @(posedge i_clk);
    i_instr <= x;
    i_instr_valid <= 1'b1;
  endtask
  task automatic fin();
    @(posedge i_clk);
    i_instr_valid <= 1'b0;
    #1;
  endtask
  task automatic step();
    @(posedge i_clk);
    #1;
  endtask
  // A bounded wait: a core that never refetches ends the run.
  task automatic wait_fetch();
    for (k = 0; k < 8 && fetch_en !== 1'b1; k++) step();
    if (fetch_en !== 1'b1) begin
      n_fail++;
      complete_run();
    end
  endtask

  task automatic t_reset();
    check(pc, 16'h0000);
    check(sp, 16'h005F);
    check(status, 8'h00);
    check(fetch_en, 1'b1);
  endtask
  // Load two operands by pops, then add and push back to back to see forwarding.
  task automatic t_alu();
    u_mem.mem[8'h60] = 8'h80;
    u_mem.mem[8'h61] = 8'h80;
    for (int i = 0; i < 2; i++) begin
      go(mk(CCR_OP_POP, 5'h10 + 5'(i), 5'h10, 6'h00));
      fin();
      check(dbus.rd, 1'b1);
      check(dbus.addr, 16'h0060 + 16'(i));
      step();
      check(sp, 16'h0060 + 16'(i));
      wait_fetch();
    end
    go(mk(CCR_OP_ADD, 5'h10, 5'h11, 6'h00));
    go(mk(CCR_OP_PUSH, 5'h10, 5'h10, 6'h00));
    fin();
    check(dbus.wr, 1'b1);
    check(dbus.addr, 16'h0061);
    check(dbus.wdata, 8'h00);
    check(status, 8'h1B);
    check(sp, 16'h0060);
    go(mk(CCR_OP_INC, 5'h10, 5'h10, 6'h00));
    go(mk(CCR_OP_PUSH, 5'h10, 5'h10, 6'h00));
    fin();
    check(dbus.wdata, 8'h01);
    check(status, 8'h01);
    check(sp, 16'h005F);
  endtask
  task automatic t_call();
    @(posedge i_clk);
    i_target <= 16'h0123;
    go(mk(CCR_OP_CALL, 5'h10, 5'h10, 6'h00));
    fin();
    check(dbus.wr, 1'b1);
    check(dbus.addr, 16'h005F);
    check(dbus.wdata, 8'h07);
    check(pc, 16'h0123);
    step();
    check(dbus.addr, 16'h005E);
    check(dbus.wdata, 8'h00);
    check(sp, 16'h005D);
    wait_fetch();
    go(mk(CCR_OP_RET, 5'h10, 5'h10, 6'h00));
    fin();
    check(dbus.addr, 16'h005E);
    step();
    check(dbus.addr, 16'h005F);
    step();
    check(sp, 16'h005F);
    check(pc, 16'h0007);
    wait_fetch();
  endtask
  // The new stack pointer 0x0180 stays above the io region, as software must ensure.
  task automatic t_io();
    go(mk(CCR_OP_OUT, 5'h11, 5'h11, 6'h10));
    fin();
    check(dbus.wr, 1'b1);
    check(dbus.addr, 16'h0010);
    check(dbus.wdata, 8'h80);
    go(mk(CCR_OP_OUT, 5'h11, 5'h11, 6'h3D));
    go(mk(CCR_OP_OUT, 5'h10, 5'h10, 6'h3E));
    fin();
    check(sp, 16'h0180);
  endtask
  task automatic t_irq();
    @(posedge i_clk);
    irq <= 4'b0110;
    for (int i = 0; i < 3; i++) begin
      step();
      check(ack, 4'h0);
    end
    go(mk(CCR_OP_SEI, 5'h10, 5'h10, 6'h00));
    go(mk(CCR_OP_NOP, 5'h10, 5'h10, 6'h00));
    fin();
    for (k = 0; k < 8 && ack === 4'h0; k++) step();
    check(ack, 4'b0010);
    @(posedge i_clk);
    irq <= 4'h0;
    #1;
    wait_fetch();
    check(status, 8'h01);
    check(sp, 16'h017E);
    check(pc, 16'h0002);
    go(mk(CCR_OP_INTERRUPT_RETURN_OP, 5'h10, 5'h10, 6'h00));
    fin();
    step();
    wait_fetch();
    check(sp, 16'h0180);
    check(status, 8'h81);
    check(pc, 16'h000C);
  endtask
  // Build the third pointer by immediate moves, read a table through it with
  // post-increment, then store through it with pre-decrement.
  task automatic t_ptr();
    ccr_instr_t x;
    x = mk(CCR_OP_MOV, 5'h1E, 5'h10, 6'h00);
    x.use_imm = 1'b1;
    x.imm = 8'h34;
    x.two_word = 1'b1;
    go(x);
    x.rd = 5'h1F;
    x.imm = 8'h12;
    go(x);
    x = mk(CCR_OP_LPM, 5'h12, 5'h10, 6'h00);
    x.ptr_sel = 2'd2;
    x.pmode = CCR_PM_POSTINC;
    go(x);
    fin();
    check(prog_addr, 16'h1234);
    check(lut_rd, 1'b1);
    check(pc, 16'h0011);
    step();
    x.op = CCR_OP_ST;
    x.rd = 5'h11;
    x.pmode = CCR_PM_PREDEC;
    go(x);
    fin();
    check(dbus.wr, 1'b1);
    check(dbus.addr, 16'h1234);
    check(dbus.wdata, 8'h80);
  endtask

  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  // Reset for three cycles, then run each scenario once.
  initial begin
    n_fail = 0;
    compares = 0;
    i_rst = 1'b1;
    i_instr = '0;
    i_instr_valid = 1'b0;
    i_target = 16'h0000;
    irq = 4'h0;
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    step();
    t_reset();
    t_alu();
    t_call();
    t_io();
    t_irq();
    t_ptr();
    complete_run();
  end
endmodule

bind ccr_core ccr_assertions #(.IRQ_N(IRQ_N), .SRAM_LAST(SRAM_LAST)) u_chk (
  .i_clk(i_clk), .i_rst(i_rst), .i_instr(i_instr), .i_instr_valid(i_instr_valid),
  .i_target(i_target), .i_data_rdata(i_data_rdata), .i_irq(i_irq),
  .o_program_counter(o_program_counter), .o_fetch_en(o_fetch_en), .o_prog_addr(o_prog_addr),
  .o_prog_lut_rd(o_prog_lut_rd), .o_dbus(o_dbus), .o_status(o_status),
  .o_stack_top_pointer(o_stack_top_pointer), .o_irq_ack(o_irq_ack));
